// ===== hw/vir_pkg.sv
// constants and types of the vectored interrupt router
// Operation
// - forward peripheral, port pin and nonmaskable requests to the core
// - maskable requests use vectored mechanism; controller supplies matching vector
// - vector index register is nine bits wide
// - page base register is sixteen bits, 16 MB table placement range
// - consecutive vectors are four bytes apart
// - each vector slot keeps a fourth byte beyond three address bytes
// - wide mode address is page base bits 15:1 joined to nine index bits
// - fixed priority; vector 040h highest, priority falls as vector rises
// - priorities 0 to 10 map vectors 040h to 068h, peripherals then unused
// - port B bits take 0A0h to 0BCh, port C from 0C0h
package vir_pkg;

  // ****************************************
  // vector layout
  // ****************************************
  localparam int VIR_IDX_W = 9;
  localparam int VIR_PAGE_W = 16;
  localparam int VIR_ADDR_W = 24;
  localparam int VIR_SLOT_BYTES = 4;
  localparam int VIR_SLOT_SHIFT = 2;
  localparam int VIR_NSRC = 35;
  localparam int VIR_PRIO_W = 6;
  localparam logic [VIR_IDX_W-1:0] VIR_VEC_BASE = 9'h040;
  localparam logic [VIR_IDX_W-1:0] VIR_VEC_LAST_INT = 9'h068;
  localparam logic [VIR_IDX_W-1:0] VIR_VEC_PORTB = 9'h0A0;
  localparam logic [VIR_IDX_W-1:0] VIR_VEC_PORTC = 9'h0C0;
  localparam int VIR_PRIO_PORTB = 24;
  localparam int VIR_N_INT = 11;
  localparam int VIR_N_PORT = 8;
  localparam logic [VIR_PAGE_W-1:0] VIR_PAGE_RST = 16'h0000;
  localparam logic [VIR_IDX_W-1:0] VIR_IDX_RST = 9'h000;

  // ****************************************
  // acknowledge sequencer states
  // ****************************************
  typedef enum logic [2:0]
  {
    VIR_IDLE = 3'b001,
    VIR_REQ = 3'b010,
    VIR_ACK = 3'b100
  } vir_state_t;

  // vector index of a priority level, four bytes per slot
  function automatic logic [VIR_IDX_W-1:0] vir_vec_of(input logic [VIR_PRIO_W-1:0] prio);
    logic [VIR_IDX_W-1:0] p;
    p = {3'b000, prio};
    vir_vec_of = VIR_VEC_BASE + (p << VIR_SLOT_SHIFT);
  endfunction : vir_vec_of

endpackage : vir_pkg

// ===== hw/vir_prio_enc.sv
// fixed priority encoder over pending maskable sources
`timescale 1ns/1ps
`default_nettype none
module vir_prio_enc
  import vir_pkg::*;
#(
  parameter int NSRC = VIR_NSRC
)
(
  // pending requests, bit index is priority
  input wire logic [NSRC-1:0] pend,
  // winner
  output logic any,
  output logic [VIR_PRIO_W-1:0] prio
);

  // lowest index wins
  always_comb
  begin
    any = 1'b0;
    prio = '0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (pend[i])
      begin
        any = 1'b1;
        prio = VIR_PRIO_W'(i);
      end
    end
  end

endmodule : vir_prio_enc
`default_nettype wire

// ===== hw/vir_top.sv
// vectored interrupt router: request gathering, arbitration, vector build
`timescale 1ns/1ps
`default_nettype none
module vir_top
  import vir_pkg::*;
(
  // system
  input wire logic clock,
  input wire logic nrst,
  // on-chip peripheral requests: network rx, tx, sys, clock synth, flash, timers 0-3
  input wire logic [8:0] periph_irq,
  // port pin requests
  input wire logic [VIR_N_PORT-1:0] port_b_irq,
  input wire logic [2:0] port_c_irq,
  // nonmaskable request pin, active low
  input wire logic nmi_n,
  // core side configuration
  input wire logic [VIR_PAGE_W-1:0] page_base,
  input wire logic wide_address_mode,
  input wire logic int_ack,
  // core side requests
  output logic int_req,
  output logic nmi_req,
  // vector answer
  output logic vec_valid,
  output logic [VIR_IDX_W-1:0] vector_offset_reg,
  output logic [VIR_ADDR_W-1:0] vec_addr,
  output logic [7:0] vec_spare
);

  // ****************************************
  // request gathering
  // ****************************************
  wire logic [VIR_NSRC-1:0] pend;
  wire logic any;
  wire logic [VIR_PRIO_W-1:0] win_prio;
  wire logic [VIR_IDX_W-1:0] win_vec;
  wire logic [VIR_ADDR_W-1:0] win_addr;

  // unused slots 9,10 and 11..23 tied inactive
  assign pend = {port_c_irq, port_b_irq, 13'h0000, 2'b00, periph_irq};

  vir_prio_enc #(.NSRC(VIR_NSRC)) u_enc
  (
    .pend(pend),
    .any(any),
    .prio(win_prio)
  );

  assign win_vec = vir_vec_of(win_prio);
  // wide mode: page base 15:1 above nine index bits, else page low byte above index low byte
  assign win_addr = wide_address_mode ? {page_base[15:1], win_vec}
                                      : {8'h00, page_base[7:0], win_vec[7:0]};

  // ****************************************
  // acknowledge sequencer
  // ****************************************
  vir_state_t state_q;
  vir_state_t state_d;
  wire logic take_ack;

  // ack only counts in request state with a source still pending
  assign take_ack = (state_q == VIR_REQ) && int_ack && any;

  always_comb
  begin
    case (state_q)
      VIR_IDLE: state_d = any ? VIR_REQ : VIR_IDLE;
      VIR_REQ: state_d = take_ack ? VIR_ACK : (any ? VIR_REQ : VIR_IDLE);
      VIR_ACK: state_d = int_ack ? VIR_ACK : VIR_IDLE;
      default: state_d = VIR_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      state_q <= VIR_IDLE;
      int_req <= 1'b0;
      nmi_req <= 1'b0;
      vec_valid <= 1'b0;
      vector_offset_reg <= VIR_IDX_RST;
      vec_addr <= {VIR_PAGE_RST[15:1], VIR_IDX_RST};
      vec_spare <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      nmi_req <= ~nmi_n;
      int_req <= any;
      vec_valid <= take_ack;
      vec_spare <= 8'h00;
      if (take_ack)
      begin
        vector_offset_reg <= win_vec;
        vec_addr <= win_addr;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_vec_on_ack;
    @(posedge clock) disable iff (!nrst)
      (state_q == VIR_REQ && int_ack && any) |=> (vec_valid && vector_offset_reg == $past(win_vec));
  endproperty
  a_vec_on_ack: assert property (p_vec_on_ack) else $error("vector not presented on ack");

  property p_top_prio;
    @(posedge clock) disable iff (!nrst)
      (state_q == VIR_REQ && int_ack && periph_irq[0]) |=> (vector_offset_reg == 9'h040);
  endproperty
  a_top_prio: assert property (p_top_prio) else $error("highest source not chosen");

  property p_spacing;
    @(posedge clock) disable iff (!nrst)
      vec_valid |-> (vector_offset_reg[1:0] == 2'b00 && vector_offset_reg >= 9'h040);
  endproperty
  a_spacing: assert property (p_spacing) else $error("vector off four byte grid");

  property p_wide;
    @(posedge clock) disable iff (!nrst)
      (state_q == VIR_REQ && int_ack && any && wide_address_mode)
        |=> vec_addr == {$past(page_base[15:1]), vector_offset_reg};
  endproperty
  a_wide: assert property (p_wide) else $error("wide address mismatch");

  property p_nmi;
    @(posedge clock) disable iff (!nrst)
      !nmi_n |=> nmi_req;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not forwarded");

  property p_req;
    @(posedge clock) disable iff (!nrst)
      (|port_b_irq) |=> int_req;
  endproperty
  a_req: assert property (p_req) else $error("port request not forwarded");

  property p_portb0;
    @(posedge clock) disable iff (!nrst)
      (state_q == VIR_REQ && int_ack && pend[23:0] == 24'h0 && port_b_irq[0])
        |=> vector_offset_reg == 9'h0A0;
  endproperty
  a_portb0: assert property (p_portb0) else $error("port b0 vector wrong");

  property p_spare;
    @(posedge clock) disable iff (!nrst)
      vec_valid |-> vec_spare == 8'h00;
  endproperty
  a_spare: assert property (p_spare) else $error("spare byte nonzero");

  // ****************************************
  // handshake checks
  // ****************************************
  sequence s_take;
    take_ack;
  endsequence

  sequence s_pulse;
    vec_valid ##1 !vec_valid;
  endsequence

  property p_answer;
    @(posedge clock) disable iff (!nrst)
      s_take |=> s_pulse;
  endproperty
  a_answer: assert property (p_answer) else $error("vector strobe not a single pulse");

  property p_refuse;
    @(posedge clock) disable iff (!nrst)
      !take_ack |=> !vec_valid;
  endproperty
  a_refuse: assert property (p_refuse) else $error("vector strobe without taken ack");

  property p_hold;
    @(posedge clock) disable iff (!nrst)
      !take_ack |=> $stable(vector_offset_reg) && $stable(vec_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("vector changed between acks");

  property p_req_drop;
    @(posedge clock) disable iff (!nrst)
      !any |=> !int_req;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request line left high");

  property p_nmi_drop;
    @(posedge clock) disable iff (!nrst)
      nmi_n |=> !nmi_req;
  endproperty
  a_nmi_drop: assert property (p_nmi_drop) else $error("nmi request left high");

  property p_narrow;
    @(posedge clock) disable iff (!nrst)
      (take_ack && !wide_address_mode)
        |=> vec_addr == {8'h00, $past(page_base[7:0]), vector_offset_reg[7:0]};
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow address mismatch");

  property p_periph_first;
    @(posedge clock) disable iff (!nrst)
      (take_ack && (|periph_irq)) |=> vector_offset_reg < VIR_VEC_PORTB;
  endproperty
  a_periph_first: assert property (p_periph_first) else $error("port beat peripheral");

  property p_portc2;
    @(posedge clock) disable iff (!nrst)
      (take_ack && pend[33:0] == '0 && port_c_irq[2])
        |=> vector_offset_reg == VIR_VEC_PORTC + 9'h008;
  endproperty
  a_portc2: assert property (p_portc2) else $error("port c2 vector wrong");

  property p_unused;
    @(posedge clock) disable iff (!nrst)
      vec_valid |-> (vector_offset_reg <= VIR_VEC_LAST_INT - 9'h008
                     || vector_offset_reg >= VIR_VEC_PORTB);
  endproperty
  a_unused: assert property (p_unused) else $error("unused slot vector issued");

  property p_onehot;
    @(posedge clock) disable iff (!nrst)
      $onehot(state_q);
  endproperty
  a_onehot: assert property (p_onehot) else $error("sequencer state not one-hot");

endmodule : vir_top
`default_nettype wire

// ===== dv/vir_core_model.sv
// core model that acknowledges vectored requests
`timescale 1ns/1ps
`default_nettype none
module vir_core_model
(
  // system
  input wire logic clock,
  input wire logic nrst,
  // handshake
  input wire logic int_req,
  input wire logic vec_valid,
  input wire logic [2:0] lag,
  output logic int_ack
);
  logic [2:0] wait_q;
  // ack raised after lag edges of request, held one cycle whether taken or not, then dropped
  always_ff @(posedge clock)
  begin
    if (!nrst || !int_req || int_ack || vec_valid)
    begin
      wait_q <= 3'h0;
      int_ack <= 1'b0;
    end
    else if (wait_q >= lag)
      int_ack <= 1'b1;
    else
      wait_q <= wait_q + 3'h1;
  end
endmodule : vir_core_model
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench of the vectored interrupt router
`timescale 1ns/1ps
`default_nettype none
module tb
  import vir_pkg::*;
;
  logic clock = 1'b0, nrst = 1'b0, nmi_n = 1'b1, wam = 1'b0;
  logic [8:0] periph = '0;
  logic [7:0] pb = '0;
  logic [2:0] pc = '0, lag = '0;
  logic [15:0] pg = '0, r = 16'h1736;
  logic int_ack, int_req, nmi_req, vv;
  logic [8:0] vo;
  logic [23:0] va;
  logic [7:0] vs;
  int mismatches = 0, cmp_count = 0;
  logic [34:0] pend;
  logic [8:0] ev;
  always #5 clock = ~clock;
  vir_top vir_top_i (.clock(clock), .nrst(nrst), .periph_irq(periph), .port_b_irq(pb),
    .port_c_irq(pc), .nmi_n(nmi_n), .page_base(pg), .wide_address_mode(wam),
    .int_ack(int_ack), .int_req(int_req), .nmi_req(nmi_req), .vec_valid(vv),
    .vector_offset_reg(vo), .vec_addr(va), .vec_spare(vs));
  vir_core_model vir_core_model_i (.clock(clock), .nrst(nrst), .int_req(int_req),
    .vec_valid(vv), .lag(lag), .int_ack(int_ack));
  // ****************
  // helpers
  // ****************
  function automatic logic [15:0] nxt(input logic [15:0] s);
    nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  function automatic logic [8:0] win(input logic [34:0] p);
    win = '0;
    for (int k = 34; k >= 0; k--)
      if (p[k])
        win = VIR_VEC_BASE + 9'(4 * k);
  endfunction : win
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  initial
  begin
    #300000;
    mismatches++;
    complete_run();
  end
  // ****************
  // main sequence
  // ****************
  initial
  begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    #1;
    check(32'({int_req, nmi_req, vv, vo, vs}), 32'h0000_0000);
    for (int i = 0; i < 200; i++)
    begin
      @(posedge clock);
      if (i == 100)
      begin
        {pc, pb, periph} <= '1;
        nmi_n <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b0;
        {pc, pb, periph} <= '0;
        nmi_n <= 1'b1;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        #1;
        check(32'({int_req, nmi_req, vv, vo, vs}), 32'h0000_0000);
        check(32'(va), 32'h0000_0000);
        @(posedge clock);
      end
      r = nxt(nxt(nxt(r)));
      pend = {3'(r[15:13] & {3{i[0]}}), r[7:0], 15'h0000, r[15:7] & 9'h1ff};
      if (i == 0) pend = 35'h0_0000_0020;
      if (i == 1) pend = 35'h4_0000_0000;
      if (i == 3) pend = 35'h0_0100_0000;
      if (i == 2 || pend == '0) pend = '1;
      pend[23:9] = '0;
      {pc, pb, periph} <= {pend[34:24], pend[8:0]};
      {wam, nmi_n, lag} <= {r[3], r[11], r[6:4]};
      pg <= nxt(r);
      ev = win(pend);
      for (int w = 0; w < 20 && vv !== 1'b1; w++)
        @(posedge clock) #1;
      check(32'(vo), 32'(ev));
      check(32'(va), wam ? {8'h00, pg[15:1], ev} : {16'h0000, pg[7:0], ev[7:0]});
      check(32'(vs), 32'h0000_0000);
      check(32'(nmi_req), 32'(!nmi_n));
      @(posedge clock);
      {pc, pb, periph} <= '0;
      repeat (2) @(posedge clock) #1;
      check(32'({int_req, vv}), 32'h0000_0000);
    end
    complete_run();
  end
endmodule : tb
`default_nettype wire
